// [hdl/reset_source_controller.sv]
// reset source sequencing, cause flags and apb register file
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps

// What this block does
// - power-up restarts fetch at address zero and presets all port bits high.
// - the supply monitor is on outside sleep mode; its reset sets the supply cause flag.
// - a low-supply indication not lasting beyond the qualify time is ignored.
// - threshold select accepts only codes 0x55, 0x33, 0x99 and 0xAA.
// - any other threshold code gives a full reset after the software reset delay.
// - a bad-threshold reset returns the threshold register to its power-on value.
// - a bad-threshold reset sets the threshold code fault flag.
// - a qualified low-supply reset leaves the threshold register unchanged.
// - the supply monitor is disabled while in power-down mode.
// - power-up loads threshold select with 0x55, the lowest threshold.
// - software clears cause flags by writing zero; writing one does nothing.
// - cause register bits 6 to 3 read as zero.
// - run-mode watchdog expiry sets expiry flag, holds reset for hold plus settle.
// - sleep-mode watchdog expiry clears only pc and sp and sets expiry flag.
// - status flags: power-up clears both, supply keeps, watchdog sets as listed.
// - power-up disables interrupts, clears watchdog, stops timer, sets stack top.
// - power-up begins execution at the first program location.
// - a bad watchdog enable code resets after the delay and sets its fault flag.
// - power-down flag cleared by power-up or watchdog clear, set by halt.
module reset_source_controller
    import reset_source_pkg::*;
#(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned QUALIFY_CYCLES = QUALIFY_CYC,
    parameter int unsigned SRESET_CYCLES = SRESET_CYC,
    parameter int unsigned HOLD_CYCLES = HOLD_CYC + SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_supply,
    input wire logic watchdog_expiry,
    input wire logic sleep_mode,
    input wire logic halt_exec,
    input wire logic watchdog_clear_exec,
    output logic sys_reset,
    output logic power_on_init,
    output logic pc_sp_clear,
    output logic supply_monitor_enable,
    output logic [7:0] threshold_code_field,
    output logic [7:0] watchdog_ctrl,
    output logic watchdog_enable,
    output status_s status
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
        $error("counter width out of range");
    end
    if (QUALIFY_CYCLES < 1 || QUALIFY_CYCLES >= (1 << CNT_W) - 1) begin : g_bad_qualify
        $error("qualify count does not fit the counter");
    end
    if (SRESET_CYCLES < 1 || SRESET_CYCLES >= (1 << CNT_W)) begin : g_bad_sreset
        $error("software reset delay does not fit the counter");
    end
    if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W)) begin : g_bad_hold
        $error("hold count does not fit the counter");
    end

    localparam logic [CNT_W-1:0] QUALIFY_LIM = CNT_W'(QUALIFY_CYCLES);
    localparam logic [CNT_W-1:0] SRESET_LIM = CNT_W'(SRESET_CYCLES);
    localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // state

    seq_state_e state_r;
    seq_state_e state_nxt;
    logic [CNT_W-1:0] qual_cnt_r;
    logic [CNT_W-1:0] qual_cnt_nxt;
    logic [CNT_W-1:0] sres_cnt_r;
    logic [CNT_W-1:0] sres_cnt_nxt;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] hold_cnt_nxt;
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;
    logic [7:0] wdt_ctrl_r;
    logic [7:0] wdt_ctrl_nxt;
    cause_s cause_r;
    cause_s cause_nxt;
    status_s status_r;
    status_s status_nxt;
    logic sys_reset_r;
    logic por_init_r;
    logic pc_sp_clear_r;
    logic mon_en_r;
    logic wdt_en_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state so every response bit comes from a flop

    wire access = psel && penable;
    wire first_access = access && !pready_r;
    wire done = access && pready_r;
    wire sel_thr = paddr == ADDR_THRESHOLD;
    wire sel_cause = paddr == ADDR_CAUSE;
    wire sel_wdt = paddr == ADDR_WDT_CTRL;
    wire sel_status = paddr == ADDR_STATUS;
    wire mapped = sel_thr || sel_cause || sel_wdt || sel_status;
    wire wr_done = done && pwrite && mapped;
    wire wr_thr = wr_done && sel_thr;
    wire wr_cause = wr_done && sel_cause;
    wire wr_wdt = wr_done && sel_wdt;

    // unimplemented cause bits are simply not stored and read as zero
    wire [7:0] cause_rd = {cause_r.system_clock_keep_on, 4'h0,
                           cause_r.supply_monitor_cause_flag,
                           cause_r.threshold_code_fault_flag,
                           cause_r.watchdog_code_fault_flag};
    wire [7:0] status_rd = {6'h00, status_r.watchdog_expiry_flag, status_r.power_down_flag};
    wire [7:0] rd_byte = sel_thr ? thr_r :
                         sel_cause ? cause_rd :
                         sel_wdt ? wdt_ctrl_r :
                         sel_status ? status_rd : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // reset sources

    wire in_run = state_r == ST_RUN;
    wire monitor_on = !sleep_mode;
    wire thr_valid = thr_r == THR_CODE_2V10 || thr_r == THR_CODE_2V55 ||
                     thr_r == THR_CODE_3V15 || thr_r == THR_CODE_3V80;
    wire [4:0] wdt_en_field = wdt_ctrl_r[7:WDT_EN_LSB];
    wire wdt_code_valid = wdt_en_field == WDT_EN_CODE_A || wdt_en_field == WDT_EN_CODE_B;
    wire code_bad = !thr_valid || !wdt_code_valid;

    // only an indication lasting beyond the qualify time counts
    wire low_qual = low_supply && monitor_on && (qual_cnt_r == QUALIFY_LIM);
    wire sres_due = code_bad && (sres_cnt_r == SRESET_LIM - 1'b1);
    wire trig_supply = in_run && low_qual;
    wire trig_thr = in_run && sres_due && !thr_valid;
    wire trig_wdc = in_run && sres_due && !wdt_code_valid;
    wire trig_wdt_run = in_run && watchdog_expiry && !sleep_mode;
    wire trig_wdt_sleep = in_run && watchdog_expiry && sleep_mode;
    wire trig_full = trig_supply || trig_thr || trig_wdc || trig_wdt_run;
    wire hold_end = state_r == ST_HOLD && hold_cnt_r == HOLD_LIM - 1'b1;

    always_comb begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        unique case (state_r)
            ST_RUN: begin
                if (trig_full) begin
                    state_nxt = ST_HOLD;
                    hold_cnt_nxt = '0;
                end
            end
            ST_HOLD: begin
                hold_cnt_nxt = hold_cnt_r + 1'b1;
                if (hold_end) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
                hold_cnt_nxt = '0;
            end
        endcase
    end

    // qualify counter saturates at the limit; it restarts whenever the level drops
    always_comb begin
        qual_cnt_nxt = '0;
        if (low_supply && monitor_on && in_run) begin
            qual_cnt_nxt = (qual_cnt_r == QUALIFY_LIM) ? qual_cnt_r : qual_cnt_r + 1'b1;
        end
    end

    // a corrected code before the delay elapses cancels the pending reset
    always_comb begin
        sres_cnt_nxt = '0;
        if (code_bad && in_run && !sres_due) begin
            sres_cnt_nxt = sres_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register next values; hardware restore and set always beat software

    always_comb begin
        thr_nxt = thr_r;
        if (wr_thr) begin
            thr_nxt = pwdata[7:0];
        end
        // a supply reset alone keeps the selected threshold
        if (trig_thr || trig_wdc || trig_wdt_run) begin
            thr_nxt = THR_RESET;
        end
    end

    always_comb begin
        wdt_ctrl_nxt = wdt_ctrl_r;
        if (wr_wdt) begin
            wdt_ctrl_nxt = pwdata[7:0];
        end
        if (trig_full) begin
            wdt_ctrl_nxt = WDT_CTRL_RESET;
        end
    end

    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt.system_clock_keep_on = pwdata[CAUSE_KEEP_ON_BIT];
            // writing one leaves a flag as it is
            cause_nxt.supply_monitor_cause_flag =
                cause_r.supply_monitor_cause_flag & pwdata[CAUSE_SUPPLY_BIT];
            cause_nxt.threshold_code_fault_flag =
                cause_r.threshold_code_fault_flag & pwdata[CAUSE_THR_BIT];
            cause_nxt.watchdog_code_fault_flag =
                cause_r.watchdog_code_fault_flag & pwdata[CAUSE_WDC_BIT];
        end
        if (trig_full) begin
            cause_nxt.system_clock_keep_on = 1'b0;
        end
        // independent sets, none masks another
        if (trig_supply) begin
            cause_nxt.supply_monitor_cause_flag = 1'b1;
        end
        if (trig_thr) begin
            cause_nxt.threshold_code_fault_flag = 1'b1;
        end
        if (trig_wdc) begin
            cause_nxt.watchdog_code_fault_flag = 1'b1;
        end
    end

    always_comb begin
        status_nxt = status_r;
        if (watchdog_clear_exec) begin
            status_nxt.power_down_flag = 1'b0;
        end
        if (halt_exec) begin
            status_nxt.power_down_flag = 1'b1;
        end
        if (trig_wdt_run || trig_wdt_sleep) begin
            status_nxt.watchdog_expiry_flag = 1'b1;
        end
        if (trig_wdt_sleep) begin
            status_nxt.power_down_flag = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flops

    // async power-on clears status and loads every default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_HOLD;
            hold_cnt_r <= '0;
            qual_cnt_r <= '0;
            sres_cnt_r <= '0;
            thr_r <= THR_RESET;
            wdt_ctrl_r <= WDT_CTRL_RESET;
            cause_r <= CAUSE_RESET;
            status_r <= STATUS_RESET;
        end else begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            qual_cnt_r <= qual_cnt_nxt;
            sres_cnt_r <= sres_cnt_nxt;
            thr_r <= thr_nxt;
            wdt_ctrl_r <= wdt_ctrl_nxt;
            cause_r <= cause_nxt;
            status_r <= status_nxt;
        end
    end

    // power-on init stays up until the first hold window ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_r <= 1'b1;
            por_init_r <= 1'b1;
            pc_sp_clear_r <= 1'b0;
            mon_en_r <= 1'b1;
            wdt_en_r <= 1'b1;
        end else begin
            sys_reset_r <= state_nxt == ST_HOLD;
            por_init_r <= por_init_r && !hold_end;
            pc_sp_clear_r <= trig_wdt_sleep;
            mon_en_r <= monitor_on;
            wdt_en_r <= wdt_code_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= first_access;
            pslverr_r <= first_access && !mapped;
            if (first_access) begin
                prdata_r <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sys_reset = sys_reset_r;
    assign power_on_init = por_init_r;
    assign pc_sp_clear = pc_sp_clear_r;
    assign supply_monitor_enable = mon_en_r;
    assign threshold_code_field = thr_r;
    assign watchdog_ctrl = wdt_ctrl_r;
    assign watchdog_enable = wdt_en_r;
    assign status = status_r;

endmodule

// [hdl/reset_source_pkg.sv]
// shared constants, register map and field layouts of the reset source controller
package reset_source_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_PS = 8000;

    // times as printed for the block, in ns
    localparam int unsigned LOW_SUPPLY_QUALIFY_TIME_NS = 120000;
    localparam int unsigned SOFTWARE_RESET_DELAY_NS = 45000;
    localparam int unsigned RESET_HOLD_DELAY_NS = 25000;
    localparam int unsigned OSCILLATOR_SETTLE_TIME_NS = 16000;

    // least times round up to whole cycles
    localparam int unsigned QUALIFY_CYC =
        (LOW_SUPPLY_QUALIFY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SRESET_CYC =
        (SOFTWARE_RESET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned HOLD_CYC =
        (RESET_HOLD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETTLE_CYC =
        (OSCILLATOR_SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // register byte addresses
    localparam logic [7:0] ADDR_THRESHOLD = 8'h00;
    localparam logic [7:0] ADDR_CAUSE = 8'h04;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // supply threshold codes
    localparam logic [7:0] THR_CODE_2V10 = 8'h55;
    localparam logic [7:0] THR_CODE_2V55 = 8'h33;
    localparam logic [7:0] THR_CODE_3V15 = 8'h99;
    localparam logic [7:0] THR_CODE_3V80 = 8'hAA;
    localparam logic [7:0] THR_RESET = THR_CODE_2V10;

    // watchdog control register: enable field in bits 7..3
    localparam int unsigned WDT_EN_LSB = 3;
    localparam logic [4:0] WDT_EN_CODE_A = 5'h0A;
    localparam logic [4:0] WDT_EN_CODE_B = 5'h15;
    localparam logic [7:0] WDT_CTRL_RESET = 8'h53;

    // cause/control register bit positions
    localparam int unsigned CAUSE_KEEP_ON_BIT = 7;
    localparam int unsigned CAUSE_SUPPLY_BIT = 2;
    localparam int unsigned CAUSE_THR_BIT = 1;
    localparam int unsigned CAUSE_WDC_BIT = 0;

    // status register bit positions
    localparam int unsigned STATUS_EXPIRY_BIT = 1;
    localparam int unsigned STATUS_PDF_BIT = 0;

    typedef struct packed {
        logic system_clock_keep_on;
        logic supply_monitor_cause_flag;
        logic threshold_code_fault_flag;
        logic watchdog_code_fault_flag;
    } cause_s;

    localparam cause_s CAUSE_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic watchdog_expiry_flag;
        logic power_down_flag;
    } status_s;

    localparam status_s STATUS_RESET = '{1'b0, 1'b0};

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } seq_state_e;

endpackage

// [test/reset_source_controller_props.sv]
// concurrent checks on the reset source controller ports
`timescale 1ns/1ps
module reset_source_controller_props
    import reset_source_pkg::*;
#(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned QUALIFY_CYCLES = QUALIFY_CYC,
    parameter int unsigned SRESET_CYCLES = SRESET_CYC,
    parameter int unsigned HOLD_CYCLES = HOLD_CYC + SETTLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic low_supply,
    input wire logic watchdog_expiry,
    input wire logic sleep_mode,
    input wire logic halt_exec,
    input wire logic watchdog_clear_exec,
    input wire logic sys_reset,
    input wire logic power_on_init,
    input wire logic pc_sp_clear,
    input wire logic supply_monitor_enable,
    input wire logic [7:0] threshold_code_field,
    input wire status_s status
);
    logic [CNT_W-1:0] ls_cnt_r;
    logic [CNT_W-1:0] hold_cnt_r;
    logic [CNT_W-1:0] bad_cnt_r;
    wire ls_on = low_supply && !sleep_mode && !sys_reset;
    wire thr_ok = threshold_code_field inside {THR_CODE_2V10, THR_CODE_2V55,
        THR_CODE_3V15, THR_CODE_3V80};
    wire thr_bad = !thr_ok && !sys_reset;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_cnt_r <= '0;
            hold_cnt_r <= '0;
            bad_cnt_r <= '0;
        end else begin
            ls_cnt_r <= ls_on ? ls_cnt_r + 1'b1 : '0;
            hold_cnt_r <= sys_reset ? hold_cnt_r + 1'b1 : '0;
            bad_cnt_r <= thr_bad ? bad_cnt_r + 1'b1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sleep_wdt;
        watchdog_expiry && sleep_mode && !sys_reset;
    endsequence
    sequence s_sleep_done;
        pc_sp_clear && status == 2'b11;
    endsequence

    chk_wdt_run_reset: assert property (
        watchdog_expiry && !sleep_mode && !sys_reset |=>
        sys_reset && status.watchdog_expiry_flag)
        else $error("run watchdog expiry gave no reset");
    chk_wdt_sleep_wake: assert property (s_sleep_wdt |=> s_sleep_done)
        else $error("sleep watchdog expiry not handled");
    chk_hold_span: assert property ($fell(sys_reset) |-> hold_cnt_r == HOLD_CYCLES)
        else $error("reset hold length wrong");
    chk_supply_qualify: assert property (
        ls_on && ls_cnt_r == QUALIFY_CYCLES |=> sys_reset)
        else $error("qualified low supply gave no reset");
    chk_bad_thr_reset: assert property (
        thr_bad && bad_cnt_r == SRESET_CYCLES - 1 |->
        ##[1:2] (sys_reset && threshold_code_field == THR_RESET))
        else $error("bad threshold code gave no reset");
    chk_pdf_halt_set: assert property (
        halt_exec && !sys_reset |=> status.power_down_flag)
        else $error("halt did not set power down flag");
    chk_pdf_clr_wdt: assert property (
        watchdog_clear_exec && !halt_exec && !sys_reset &&
        !(watchdog_expiry && sleep_mode) |=> !status.power_down_flag)
        else $error("watchdog clear left power down flag");
    chk_por_init_hold: assert property (power_on_init |-> sys_reset)
        else $error("power on init outside reset hold");
    chk_monitor_sleep_off: assert property (
        $stable(sleep_mode) |-> supply_monitor_enable == !sleep_mode)
        else $error("supply monitor enable wrong for mode");
endmodule

bind reset_source_controller reset_source_controller_props #(.CNT_W(CNT_W),
    .QUALIFY_CYCLES(QUALIFY_CYCLES), .SRESET_CYCLES(SRESET_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
    .low_supply(low_supply), .watchdog_expiry(watchdog_expiry), .sleep_mode(sleep_mode),
    .halt_exec(halt_exec), .watchdog_clear_exec(watchdog_clear_exec),
    .sys_reset(sys_reset), .power_on_init(power_on_init), .pc_sp_clear(pc_sp_clear),
    .supply_monitor_enable(supply_monitor_enable),
    .threshold_code_field(threshold_code_field), .status(status));

// [test/reset_source_controller_tb_top.sv]
// self-checking testbench for the reset source controller
`timescale 1ns/1ps
module reset_source_controller_tb_top
    import reset_source_pkg::*;
;
    // short counts keep the run brief
    localparam int unsigned QC = 20;
    localparam int unsigned SC = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic low_supply = 1'b0;
    logic watchdog_expiry = 1'b0;
    logic sleep_mode = 1'b0;
    logic halt_exec = 1'b0;
    logic watchdog_clear_exec = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_reset;
    logic power_on_init;
    logic pc_sp_clear;
    logic supply_monitor_enable;
    logic [7:0] threshold_code_field;
    logic [7:0] watchdog_ctrl;
    logic watchdog_enable;
    status_s status;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic rerr;
    logic [25:0] rows [10];

    always #4 pclk = ~pclk;

    reset_source_controller #(.QUALIFY_CYCLES(QC), .SRESET_CYCLES(SC),
        .HOLD_CYCLES(12)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_supply(low_supply),
        .watchdog_expiry(watchdog_expiry), .sleep_mode(sleep_mode), .halt_exec(halt_exec),
        .watchdog_clear_exec(watchdog_clear_exec), .sys_reset(sys_reset),
        .power_on_init(power_on_init), .pc_sp_clear(pc_sp_clear),
        .supply_monitor_enable(supply_monitor_enable),
        .threshold_code_field(threshold_code_field), .watchdog_ctrl(watchdog_ctrl),
        .watchdog_enable(watchdog_enable), .status(status));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (sys_reset !== lvl && n < 200) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("sys_reset", sys_reset, lvl);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b0);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_count++;
        $display("BAD watchdog exp done seen hang");
        stop_test;
    end

    initial begin
        // row: write, address, write data, read data, slave error
        rows = '{{1'b1, ADDR_THRESHOLD, 8'h33, 8'h33, 1'b0},
            {1'b1, ADDR_THRESHOLD, 8'h99, 8'h99, 1'b0},
            {1'b1, ADDR_THRESHOLD, 8'hAA, 8'hAA, 1'b0},
            {1'b1, ADDR_THRESHOLD, 8'h55, 8'h55, 1'b0},
            {1'b0, ADDR_WDT_CTRL, 8'h00, 8'h53, 1'b0},
            {1'b0, ADDR_STATUS, 8'h00, 8'h00, 1'b0},
            {1'b0, ADDR_CAUSE, 8'h00, 8'h00, 1'b0},
            {1'b1, ADDR_CAUSE, 8'hFF, 8'h80, 1'b0},
            {1'b1, ADDR_CAUSE, 8'h00, 8'h00, 1'b0},
            {1'b1, 8'h10, 8'hFF, 8'h00, 1'b1}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("por_init", power_on_init, 1'b1);
        wait_rst(1'b0);
        chk("por_init", power_on_init, 1'b0);
        chk("thr", threshold_code_field, 8'h55);
        chk("status", status, 2'b00);
        foreach (rows[i]) begin
            if (rows[i][25]) apb(1'b1, rows[i][24:17], 32'(rows[i][16:9]));
            apb(1'b0, rows[i][24:17], '0);
            chk("rdata", rd, 32'(rows[i][8:1]));
            chk("slverr", rerr, rows[i][0]);
        end
        $display("register table done");
        // short dip must be ignored, pdf set first to see it kept
        @(posedge pclk);
        halt_exec <= 1'b1;
        @(posedge pclk);
        halt_exec <= 1'b0;
        low_supply <= 1'b1;
        repeat (QC) @(posedge pclk);
        low_supply <= 1'b0;
        tick(4);
        chk("sys_reset", sys_reset, 1'b0);
        chk("status", status, 2'b01);
        apb(1'b1, ADDR_THRESHOLD, 32'h0000_0099);
        @(posedge pclk);
        low_supply <= 1'b1;
        wait_rst(1'b1);
        @(posedge pclk);
        low_supply <= 1'b0;
        wait_rst(1'b0);
        chk("thr", threshold_code_field, 8'h99);
        chk("status", status, 2'b01);
        apb(1'b0, ADDR_CAUSE, '0);
        chk("cause", rd, 32'h0000_0004);
        apb(1'b1, ADDR_CAUSE, '0);
        apb(1'b0, ADDR_CAUSE, '0);
        chk("cause", rd, 32'h0000_0000);
        $display("supply reset done");
        @(posedge pclk);
        sleep_mode <= 1'b1;
        low_supply <= 1'b1;
        tick(3 * QC);
        chk("sys_reset", sys_reset, 1'b0);
        chk("mon_en", supply_monitor_enable, 1'b0);
        @(posedge pclk);
        low_supply <= 1'b0;
        watchdog_expiry <= 1'b1;
        @(posedge pclk);
        watchdog_expiry <= 1'b0;
        #1;
        chk("pc_sp", pc_sp_clear, 1'b1);
        chk("status", status, 2'b11);
        chk("sys_reset", sys_reset, 1'b0);
        chk("thr", threshold_code_field, 8'h99);
        @(posedge pclk);
        sleep_mode <= 1'b0;
        watchdog_clear_exec <= 1'b1;
        @(posedge pclk);
        watchdog_clear_exec <= 1'b0;
        tick(1);
        chk("status", status, 2'b10);
        $display("sleep watchdog done");
        // fresh power-on so the sticky expiry flag starts clear
        do_reset;
        chk("status", status, 2'b00);
        apb(1'b1, ADDR_THRESHOLD, 32'h0000_00AA);
        apb(1'b1, ADDR_WDT_CTRL, 32'h0000_00AB);
        @(posedge pclk);
        watchdog_expiry <= 1'b1;
        @(posedge pclk);
        watchdog_expiry <= 1'b0;
        #1;
        chk("sys_reset", sys_reset, 1'b1);
        chk("status", status, 2'b10);
        chk("thr", threshold_code_field, 8'h55);
        chk("wdt_ctrl", watchdog_ctrl, 8'h53);
        wait_rst(1'b0);
        $display("run watchdog done");
        // corrected before the delay: no reset
        apb(1'b1, ADDR_THRESHOLD, 32'h0000_0012);
        apb(1'b1, ADDR_THRESHOLD, 32'h0000_0033);
        tick(2 * SC);
        chk("sys_reset", sys_reset, 1'b0);
        apb(1'b1, ADDR_THRESHOLD, 32'h0000_0012);
        wait_rst(1'b1);
        chk("thr", threshold_code_field, 8'h55);
        wait_rst(1'b0);
        apb(1'b0, ADDR_CAUSE, '0);
        chk("cause", rd, 32'h0000_0002);
        apb(1'b1, ADDR_WDT_CTRL, '0);
        tick(2);
        chk("wdt_en", watchdog_enable, 1'b0);
        wait_rst(1'b1);
        wait_rst(1'b0);
        chk("wdt_ctrl", watchdog_ctrl, 8'h53);
        apb(1'b0, ADDR_CAUSE, '0);
        chk("cause", rd, 32'h0000_0003);
        $display("code fault resets done");
        stop_test;
    end
endmodule
